// file: core/buck_sup_pkg.sv
// Shared constants and types for the converter enable and fault supervisor.
package buck_sup_pkg;

   localparam logic [7:0] OFS_STATUS = 8'h01;
   localparam logic [7:0] OFS_EN_HIGH = 8'h10;
   localparam logic [7:0] OFS_EN_LOW = 8'h11;
   localparam logic [7:0] OFS_ILIM = 8'h16;
   localparam logic [7:0] OFS_FLAGS = 8'h18;

   localparam int unsigned STAT_GOOD_BIT = 0;
   localparam int unsigned STAT_REG_BIT = 1;
   localparam int unsigned STAT_UV_BIT = 2;
   localparam int unsigned STAT_OT_BIT = 3;
   localparam int unsigned EN_BIT = 0;
   localparam int unsigned FLAG_LOCKOUT_BIT = 0;
   localparam int unsigned FLAG_SHORT_BIT = 1;
   localparam int unsigned FLAG_OC_BIT = 2;

   localparam logic [7:0] EN_RESET = 8'h01;
   localparam logic [7:0] ILIM_RESET = 8'h03;
   localparam logic [2:0] FLAGS_RESET = 3'h0;

   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned RAMP_STEP_US = 10;
   localparam int unsigned RAMP_STEP_CYC = RAMP_STEP_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned RAMP_STEP_MV = 3;
   localparam int unsigned SOFTSTART_US = 420;
   localparam int unsigned SOFTSTART_CYC = SOFTSTART_US * 1000 / CLK_PERIOD_NS;

   // Analog comparator and pin levels, all from outside the clock domain.
   typedef struct packed {
      logic en_pin;
      logic preset_select_pin;
      logic pvin_rise;
      logic pvin_fall;
      logic vout_good;
      logic vout_under;
      logic hs_over_limit;
      logic over_temp;
      logic temp_below_fall;
   } sense_t;

   typedef struct packed {
      logic [1:0] bank;
      logic [15:0] target_mv;
   } preset_t;

   typedef enum logic [4:0] {
      ST_OFF = 5'h01,
      ST_SOFT = 5'h02,
      ST_RUN = 5'h04,
      ST_UV_LATCH = 5'h08,
      ST_OT_LATCH = 5'h10
   } conv_state_t;

endpackage

// file: core/ref_stepper.sv
// Output reference that steps toward its target or jumps to it.
`timescale 1ns/10ps
`default_nettype none
module ref_stepper #(
   parameter int unsigned W = 16,
   parameter logic [15:0] STEP = 16'h0003
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic tick,
   input wire logic jump,
   input wire logic [W-1:0] target,
   output logic [W-1:0] ref_level,
   output logic settled
);

   logic [W-1:0] step;
   assign step = STEP[W-1:0];
   assign settled = (ref_level == target);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ref_level <= '0;
      end else if (jump) begin
         ref_level <= target; // RULE3
      end else if (tick && ref_level != target) begin
         if (target > ref_level) begin
            ref_level <= (target - ref_level > step) ?
               ref_level + step : target; // RULE2
         end else begin
            ref_level <= (ref_level - target > step) ?
               ref_level - step : target; // RULE2
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_ramp_up_step: assert property ( // RULE2
      !jump && tick && target > ref_level && target - ref_level > step
      |=> ref_level == $past(ref_level) + step)
      else $error("reference up step is not one step");
   a_ramp_hold: assert property ( // RULE2
      !jump && !tick |=> $stable(ref_level))
      else $error("reference moved between steps");
   a_bank_jump: assert property (jump |=> ref_level == $past(target)) // RULE3
      else $error("reference did not jump to target");

endmodule
`default_nettype wire

// file: core/buck_enable_fault_supervisor.sv
// Enable, soft start, protection latches and register file of the converter.
// Function
// RULE1 - Enable bit at preset_high_enable_ctrl serves select pin high, bit at preset_low_enable_ctrl serves low.
// RULE2 - On a setting change the reference moves 3 mV every 10 us.
// RULE3 - Steps only within one bank; a bank change loads the target at once.
// RULE4 - Whenever the converter is off, the output discharge path is on.
// RULE5 - Register power_good_status shows output good while output is above its threshold.
// RULE6 - Soft start once input reaches 2.4 V; shut down at 2.3 V.
// RULE7 - Input lockout is recorded in a sticky flag at fault_event_flags.
// RULE8 - Output below half target after soft start latches regulation off.
// RULE9 - Output latch freed by input loss, pin toggle or enable bit toggle.
// RULE10 - Output undervoltage is recorded in a sticky flag at fault_event_flags.
// RULE11 - High-side current over limit holds off the next on pulse.
// RULE12 - Overcurrent is recorded in a sticky flag at fault_event_flags.
// RULE13 - Current limit level comes from bits 1:0 of register current_limit_ctrl.
// RULE14 - Over-temperature latches regulation off until temperature falls.
// RULE15 - A cleared selected enable bit keeps the converter off.
// RULE16 - Select pin chooses one of two presets with no added latency; the code passes the pin through two flops first.
// RULE17 - Event flags stay set; host clears one by writing one to it.
`timescale 1ns/10ps
`default_nettype none
module buck_enable_fault_supervisor #(
   parameter int unsigned SOFTSTART_CYC = buck_sup_pkg::SOFTSTART_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire buck_sup_pkg::sense_t sense,
   input wire buck_sup_pkg::preset_t preset_high,
   input wire buck_sup_pkg::preset_t preset_low,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic conv_enable,
   output logic softstart_active,
   output logic discharge_on,
   output logic pulse_hold,
   output logic [1:0] current_limit_level,
   output logic [15:0] ref_level,
   output logic ref_settled
);

   localparam int unsigned SS_W = $clog2(SOFTSTART_CYC + 1);
   localparam int unsigned TK_W = $clog2(buck_sup_pkg::RAMP_STEP_CYC + 1);
   localparam logic [SS_W-1:0] SS_LAST = SS_W'(SOFTSTART_CYC - 1);
   localparam logic [TK_W-1:0] TK_LAST =
      TK_W'(buck_sup_pkg::RAMP_STEP_CYC - 1);

   function automatic logic hit(input logic [7:0] addr,
                                input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   buck_sup_pkg::sense_t sense_meta;
   buck_sup_pkg::sense_t s;
   buck_sup_pkg::conv_state_t state;
   buck_sup_pkg::conv_state_t next_state;
   buck_sup_pkg::preset_t sel;
   logic [7:0] en_high;
   logic [7:0] en_low;
   logic [7:0] ilim;
   logic [2:0] flags;
   logic [2:0] flag_set;
   logic [2:0] flag_clr;
   logic [7:0] status;
   logic [SS_W-1:0] ss_cnt;
   logic [TK_W-1:0] tk_cnt;
   logic tick;
   logic pvin_ok;
   logic sel_enable;
   logic enable_req;
   logic regulating;
   logic oc_prev;
   logic [1:0] bank_now;
   logic ramp_jump;

   // Every pin and comparator level passes two flops before use.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sense_meta <= '0;
         s <= '0;
      end else begin
         sense_meta <= sense;
         s <= sense_meta;
      end
   end

   assign sel = s.preset_select_pin ? preset_high : preset_low; // RULE16
   assign sel_enable = s.preset_select_pin ?
                       en_high[buck_sup_pkg::EN_BIT] :
                       en_low[buck_sup_pkg::EN_BIT]; // RULE1
   assign enable_req = s.en_pin && sel_enable && pvin_ok; // RULE15
   assign regulating = (state == buck_sup_pkg::ST_SOFT) ||
                       (state == buck_sup_pkg::ST_RUN);

   // Input lockout with hysteresis between the two comparator levels.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pvin_ok <= 1'b0;
      end else if (s.pvin_fall) begin
         pvin_ok <= 1'b0; // RULE6
      end else if (s.pvin_rise) begin
         pvin_ok <= 1'b1; // RULE6
      end
   end

   // Over-temperature wins over everything; dropping the enable request is
   // the only other way out of the undervoltage latch.
   always_comb begin
      next_state = state;
      case (state)
         buck_sup_pkg::ST_OFF: begin
            if (s.over_temp) begin
               next_state = buck_sup_pkg::ST_OT_LATCH;
            end else if (enable_req) begin
               next_state = buck_sup_pkg::ST_SOFT; // RULE6
            end
         end
         buck_sup_pkg::ST_SOFT: begin
            if (s.over_temp) begin
               next_state = buck_sup_pkg::ST_OT_LATCH;
            end else if (!enable_req) begin
               next_state = buck_sup_pkg::ST_OFF;
            end else if (ss_cnt == SS_LAST) begin
               next_state = buck_sup_pkg::ST_RUN;
            end
         end
         buck_sup_pkg::ST_RUN: begin
            if (s.over_temp) begin
               next_state = buck_sup_pkg::ST_OT_LATCH; // RULE14
            end else if (!enable_req) begin
               next_state = buck_sup_pkg::ST_OFF; // RULE6
            end else if (s.vout_under) begin
               next_state = buck_sup_pkg::ST_UV_LATCH; // RULE8
            end
         end
         buck_sup_pkg::ST_UV_LATCH: begin
            if (s.over_temp) begin
               next_state = buck_sup_pkg::ST_OT_LATCH;
            end else if (!enable_req) begin
               next_state = buck_sup_pkg::ST_OFF; // RULE9
            end
         end
         buck_sup_pkg::ST_OT_LATCH: begin
            if (s.temp_below_fall && !s.over_temp) begin
               next_state = buck_sup_pkg::ST_OFF; // RULE14
            end
         end
         default: next_state = buck_sup_pkg::ST_OFF;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= buck_sup_pkg::ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ss_cnt <= '0;
      end else if (state != buck_sup_pkg::ST_SOFT) begin
         ss_cnt <= '0;
      end else if (ss_cnt != SS_LAST) begin
         ss_cnt <= ss_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         conv_enable <= 1'b0;
         softstart_active <= 1'b0;
         discharge_on <= 1'b1;
      end else begin
         conv_enable <= (next_state == buck_sup_pkg::ST_SOFT) ||
                        (next_state == buck_sup_pkg::ST_RUN);
         softstart_active <= (next_state == buck_sup_pkg::ST_SOFT);
         discharge_on <= (next_state != buck_sup_pkg::ST_SOFT) &&
                         (next_state != buck_sup_pkg::ST_RUN); // RULE4
      end
   end

   // Cycle-by-cycle limit: the hold follows the comparator while switching.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pulse_hold <= 1'b0;
         oc_prev <= 1'b0;
      end else begin
         pulse_hold <= regulating && s.hs_over_limit; // RULE11
         oc_prev <= s.hs_over_limit;
      end
   end

   // Ramp tick divider, one pulse every step interval.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tk_cnt <= '0;
      end else if (tk_cnt == TK_LAST) begin
         tk_cnt <= '0;
      end else begin
         tk_cnt <= tk_cnt + 1'b1;
      end
   end
   assign tick = (tk_cnt == TK_LAST);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bank_now <= 2'h0;
      end else begin
         bank_now <= sel.bank;
      end
   end
   // Off or across banks the reference loads directly; no ramp is attempted.
   assign ramp_jump = !regulating || (sel.bank != bank_now); // RULE3

   ref_stepper #(
      .W(16),
      .STEP(16'(buck_sup_pkg::RAMP_STEP_MV))
   ) u_ref (
      .clk(clk),
      .arst_n(arst_n),
      .tick(tick),
      .jump(ramp_jump),
      .target(sel.target_mv),
      .ref_level(ref_level),
      .settled(ref_settled)
   ); // RULE2

   // Control registers.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         en_high <= buck_sup_pkg::EN_RESET;
         en_low <= buck_sup_pkg::EN_RESET;
         ilim <= buck_sup_pkg::ILIM_RESET;
      end else if (reg_wr) begin
         if (hit(reg_addr, buck_sup_pkg::OFS_EN_HIGH)) begin
            en_high <= reg_wdata; // RULE1
         end
         if (hit(reg_addr, buck_sup_pkg::OFS_EN_LOW)) begin
            en_low <= reg_wdata; // RULE1
         end
         if (hit(reg_addr, buck_sup_pkg::OFS_ILIM)) begin
            ilim <= reg_wdata;
         end
      end
   end
   assign current_limit_level = ilim[1:0]; // RULE13

   // Sticky event flags; a new event in the clearing cycle keeps the flag.
   always_comb begin
      flag_set = 3'h0;
      flag_set[buck_sup_pkg::FLAG_LOCKOUT_BIT] =
         pvin_ok && s.pvin_fall; // RULE7
      flag_set[buck_sup_pkg::FLAG_SHORT_BIT] =
         (state == buck_sup_pkg::ST_RUN) && enable_req && !s.over_temp &&
         s.vout_under; // RULE10
      flag_set[buck_sup_pkg::FLAG_OC_BIT] =
         regulating && s.hs_over_limit && !oc_prev; // RULE12
      flag_clr = (reg_wr && hit(reg_addr, buck_sup_pkg::OFS_FLAGS)) ?
                 reg_wdata[2:0] : 3'h0;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flags <= buck_sup_pkg::FLAGS_RESET;
      end else begin
         flags <= (flags & ~flag_clr) | flag_set; // RULE17
      end
   end

   always_comb begin
      status = 8'h00;
      status[buck_sup_pkg::STAT_GOOD_BIT] = s.vout_good; // RULE5
      status[buck_sup_pkg::STAT_REG_BIT] = regulating;
      status[buck_sup_pkg::STAT_UV_BIT] = (state == buck_sup_pkg::ST_UV_LATCH);
      status[buck_sup_pkg::STAT_OT_BIT] = (state == buck_sup_pkg::ST_OT_LATCH);
   end

   // Read data is registered one cycle after the read strobe.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (hit(reg_addr, buck_sup_pkg::OFS_STATUS)) begin
            reg_rdata <= status; // RULE5
         end else if (hit(reg_addr, buck_sup_pkg::OFS_EN_HIGH)) begin
            reg_rdata <= en_high;
         end else if (hit(reg_addr, buck_sup_pkg::OFS_EN_LOW)) begin
            reg_rdata <= en_low;
         end else if (hit(reg_addr, buck_sup_pkg::OFS_ILIM)) begin
            reg_rdata <= ilim;
         end else if (hit(reg_addr, buck_sup_pkg::OFS_FLAGS)) begin
            reg_rdata <= {5'h00, flags};
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_enable_gate: assert property ( // RULE15
      regulating && !sel_enable && !s.over_temp
      |=> state == buck_sup_pkg::ST_OFF)
      else $error("converter stayed on with enable bit clear");
   a_discharge_off: assert property ( // RULE4
      regulating && !enable_req && !s.over_temp
      |=> discharge_on && !conv_enable)
      else $error("no discharge after shutdown");
   a_good_read: assert property ( // RULE5
      reg_rd && s.vout_good && reg_addr == buck_sup_pkg::OFS_STATUS
      |=> reg_rdata[0])
      else $error("good bit not read back");
   a_lockout_shut: assert property ( // RULE6
      pvin_ok && s.pvin_fall && state == buck_sup_pkg::ST_RUN &&
      !s.over_temp |=> !pvin_ok ##1 state == buck_sup_pkg::ST_OFF)
      else $error("input drop did not shut down");
   a_lockout_flag: assert property ( // RULE7
      pvin_ok && s.pvin_fall |=> flags[0])
      else $error("lockout flag not set");
   a_uv_latch: assert property ( // RULE8
      state == buck_sup_pkg::ST_RUN && enable_req && !s.over_temp &&
      s.vout_under |=> state == buck_sup_pkg::ST_UV_LATCH && flags[1])
      else $error("undervoltage did not latch");
   a_uv_release: assert property ( // RULE9
      state == buck_sup_pkg::ST_UV_LATCH && !s.over_temp && !enable_req
      |=> state == buck_sup_pkg::ST_OFF)
      else $error("undervoltage latch not released");
   a_oc_hold: assert property ( // RULE11
      regulating && s.hs_over_limit |=> pulse_hold)
      else $error("on pulse not held off");
   a_oc_flag: assert property ( // RULE12
      $rose(s.hs_over_limit) && regulating |=> flags[2])
      else $error("overcurrent flag not set");
   a_limit_field: assert property ( // RULE13
      reg_wr && reg_addr == buck_sup_pkg::OFS_ILIM
      |=> current_limit_level == $past(reg_wdata[1:0]))
      else $error("limit field not taken");
   // The latch holds while the temperature has not fallen back.
   a_temp_latch: assert property ( // RULE14
      s.over_temp ||
      (state == buck_sup_pkg::ST_OT_LATCH && !s.temp_below_fall)
      |=> state == buck_sup_pkg::ST_OT_LATCH)
      else $error("temperature latch not held");
   a_flag_sticky: assert property ( // RULE17
      flags[0] &&
      !(reg_wr && reg_addr == buck_sup_pkg::OFS_FLAGS && reg_wdata[0])
      |=> flags[0])
      else $error("flag lost without clear");

endmodule
`default_nettype wire

// file: test/host_model.sv
// Host register master model driving the parallel register strobe port.
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input wire logic clk,
   output var logic reg_wr,
   output var logic reg_rd,
   output var logic [7:0] reg_addr,
   output var logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // Idle address and data lines show the inverse of their last value.
   task automatic release_bus();
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
   endtask

   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'h1;
      @(negedge clk);
      release_bus();
   endtask

   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'h1;
      @(negedge clk);
      d = reg_rdata;
      release_bus();
   endtask

   // Shutting the converter down and enabling it again clears a stop.
   task automatic cycle_enable(input logic [7:0] a);
      write_reg(a, 8'h00);
      repeat (4) @(negedge clk);
      write_reg(a, 8'h01);
   endtask
endmodule
`default_nettype wire

// file: test/buck_enable_fault_supervisor_test.sv
// Self-checking bench for the converter enable and fault supervisor.
`timescale 1ns/10ps
`default_nettype none
module buck_enable_fault_supervisor_test;
   localparam int unsigned SS = 20;
   logic clk = 1'h0;
   logic arst_n = 1'h0;
   buck_sup_pkg::sense_t sense = '0;
   buck_sup_pkg::preset_t preset_high = {2'h1, 16'h03E8};
   buck_sup_pkg::preset_t preset_low = {2'h1, 16'h03E8};
   logic reg_wr, reg_rd, conv_enable, softstart_active;
   logic discharge_on, pulse_hold, ref_settled;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, val;
   logic [1:0] current_limit_level;
   logic [15:0] ref_level, prev;
   int err_total = 0;
   int samples_checked = 0;
   int exp_reg[int];
   int exp_flags = 0;
   int gap;

   always #10 clk = ~clk;

   buck_enable_fault_supervisor #(.SOFTSTART_CYC(SS)) i_dut (
      .clk(clk), .arst_n(arst_n), .sense(sense),
      .preset_high(preset_high), .preset_low(preset_low),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .conv_enable(conv_enable), .softstart_active(softstart_active),
      .discharge_on(discharge_on), .pulse_hold(pulse_hold),
      .current_limit_level(current_limit_level),
      .ref_level(ref_level), .ref_settled(ref_settled)
   );

   host_model i_host (
      .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
   );

   task automatic close_out();
      $display("Counts: %0d checks, %0d mismatches", samples_checked,
               err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time,
                  seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      i_host.read_reg(a, rd);
      check({8'h00, rd}, {8'h00, exp});
   endtask

   // The model follows writes to the flag register and to registers in exp_reg: flags clear where a one is written.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host.write_reg(a, d);
      if (a == buck_sup_pkg::OFS_FLAGS) begin
         exp_flags = exp_flags & ~int'(d);
      end else if (exp_reg.exists(int'(a))) begin
         exp_reg[int'(a)] = int'(d);
      end
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      $display("Watchdog expired before the tests ended");
      close_out();
   end

   initial begin
      void'($urandom(30));
      exp_reg[8'h10] = 1;
      exp_reg[8'h11] = 1;
      exp_reg[8'h16] = 3;
      step(2);
      arst_n = 1'h1;
      check(discharge_on, 1'h1);
      check(current_limit_level, 2'h3);
      foreach (exp_reg[a]) rd_chk(a[7:0], exp_reg[a][7:0]);
      rd_chk(buck_sup_pkg::OFS_FLAGS, 8'h00);
      rd_chk(8'h20, 8'h00);
      $display("Test reset values done");

      wr(buck_sup_pkg::OFS_EN_HIGH, 8'h00);
      sense.en_pin = 1'h1;
      sense.pvin_rise = 1'h1;
      sense.preset_select_pin = 1'h1;
      step(6);
      check(conv_enable, 1'h0);
      check(discharge_on, 1'h1);
      sense.preset_select_pin = 1'h0;
      step(6);
      check(conv_enable, 1'h1);
      check(softstart_active, 1'h1);
      check(discharge_on, 1'h0);
      wr(buck_sup_pkg::OFS_EN_HIGH, 8'h01);
      sense.preset_select_pin = 1'h1;
      step(SS + 6);
      check(softstart_active, 1'h0);
      check(conv_enable, 1'h1);
      rd_chk(buck_sup_pkg::OFS_STATUS, 8'h02);
      $display("Test enable select done");

      repeat (4) begin
         val = 8'($urandom());
         wr(buck_sup_pkg::OFS_ILIM, val);
         check(current_limit_level, val[1:0]);
         rd_chk(buck_sup_pkg::OFS_ILIM, 8'(exp_reg[8'h16]));
         wr(buck_sup_pkg::OFS_EN_LOW, val);
         rd_chk(buck_sup_pkg::OFS_EN_LOW, 8'(exp_reg[8'h11]));
      end
      $display("Test current limit done");

      check(ref_level, 16'h03E8);
      preset_high.target_mv = 16'h03F1;
      for (int i = 0; i < 3; i++) begin
         prev = ref_level;
         for (gap = 0; gap < 600 && ref_level === prev; gap++) step(1);
         check(ref_level, prev + 16'h0003);
         // After the first step the spacing must be one full step interval.
         if (i > 0) begin
            check(16'(gap), 16'(buck_sup_pkg::RAMP_STEP_CYC));
         end
      end
      check(ref_settled, 1'h1);
      preset_high = {2'h2, 16'h07D0};
      step(2);
      check(ref_level, 16'h07D0);
      $display("Test reference ramp done");

      sense.vout_good = 1'h1;
      step(5);
      rd_chk(buck_sup_pkg::OFS_STATUS, 8'h03);
      sense.vout_good = 1'h0;
      step(5);
      rd_chk(buck_sup_pkg::OFS_STATUS, 8'h02);
      $display("Test output good done");

      sense.hs_over_limit = 1'h1;
      step(5);
      check(pulse_hold, 1'h1);
      sense.hs_over_limit = 1'h0;
      step(5);
      check(pulse_hold, 1'h0);
      exp_flags = exp_flags | 4;
      rd_chk(buck_sup_pkg::OFS_FLAGS, 8'(exp_flags));
      wr(buck_sup_pkg::OFS_FLAGS, 8'h04);
      rd_chk(buck_sup_pkg::OFS_FLAGS, 8'(exp_flags));
      $display("Test overcurrent done");

      sense.vout_under = 1'h1;
      step(5);
      check(conv_enable, 1'h0);
      check(discharge_on, 1'h1);
      sense.vout_under = 1'h0;
      step(5);
      check(conv_enable, 1'h0);
      exp_flags = exp_flags | 2;
      rd_chk(buck_sup_pkg::OFS_STATUS, 8'h04);
      rd_chk(buck_sup_pkg::OFS_FLAGS, 8'(exp_flags));
      i_host.cycle_enable(buck_sup_pkg::OFS_EN_HIGH);
      step(5);
      check(conv_enable, 1'h1);
      step(SS + 2);
      sense.vout_under = 1'h1;
      step(5);
      sense.vout_under = 1'h0;
      check(conv_enable, 1'h0);
      sense.en_pin = 1'h0;
      step(5);
      sense.en_pin = 1'h1;
      step(5);
      check(conv_enable, 1'h1);
      rd_chk(buck_sup_pkg::OFS_FLAGS, 8'(exp_flags));
      wr(buck_sup_pkg::OFS_FLAGS, 8'h02);
      rd_chk(buck_sup_pkg::OFS_FLAGS, 8'(exp_flags));
      step(SS);
      $display("Test undervoltage latch done");

      sense.over_temp = 1'h1;
      step(5);
      check(conv_enable, 1'h0);
      rd_chk(buck_sup_pkg::OFS_STATUS, 8'h08);
      sense.over_temp = 1'h0;
      step(5);
      check(conv_enable, 1'h0);
      sense.temp_below_fall = 1'h1;
      step(5);
      check(conv_enable, 1'h1);
      sense.temp_below_fall = 1'h0;
      step(SS + 5);
      $display("Test over temperature done");

      sense.pvin_rise = 1'h0;
      sense.pvin_fall = 1'h1;
      step(5);
      check(conv_enable, 1'h0);
      exp_flags = exp_flags | 1;
      rd_chk(buck_sup_pkg::OFS_FLAGS, 8'(exp_flags));
      wr(buck_sup_pkg::OFS_FLAGS, 8'h01);
      rd_chk(buck_sup_pkg::OFS_FLAGS, 8'(exp_flags));
      $display("Test input lockout done");
      close_out();
   end
endmodule
`default_nettype wire
